// ===== design/uaar_top.sv
// Purpose: Address recognition filter and receive buffer of a serial port
// Assumes: Receiver on the same clock hands over complete frames
// Notes:   Accepted frames are buffered; reading the data register pops one
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

// --------------------------------------------------------------------
// Receive buffer
// --------------------------------------------------------------------
module uaar_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input  wire logic                       i_mclk,
	input  wire logic                       i_rst_b,
	input  wire logic                       i_in_valid,
	output logic                            o_in_ready,
	input  wire logic [WIDTH-1:0]           i_in_data,
	output logic                            o_out_valid,
	input  wire logic                       i_out_ready,
	output logic [WIDTH-1:0]                o_out_data,
	output logic [$clog2(DEPTH):0]          o_level
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    wr_ptr_d;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW-1:0]    rd_ptr_d;
	logic [PW:0]      count_q;
	logic [PW:0]      count_d;
	logic             push;
	logic             pop;

	// Handshake and occupancy
	assign o_in_ready  = (count_q != DEPTH[PW:0]);
	assign o_out_valid = (count_q != '0);
	assign push        = i_in_valid && o_in_ready;
	assign pop         = i_out_ready && o_out_valid;
	assign o_out_data  = mem_q[rd_ptr_q];
	assign o_level     = count_q;

	// Pointer and count updates
	assign wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
	assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
	assign count_d  = (push && !pop) ? count_q + 1'b1 :
	                  (pop && !push) ? count_q - 1'b1 : count_q;

	// --------------------------------------------------------------------
	// Write pointer
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_ptr_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
		end
	end

	// --------------------------------------------------------------------
	// Read pointer
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rd_ptr_q <= '0;
		end else begin
			rd_ptr_q <= rd_ptr_d;
		end
	end

	// --------------------------------------------------------------------
	// Occupancy
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	// Storage, not reset
	always_ff @(posedge i_mclk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

endmodule

// --------------------------------------------------------------------
// Address recognition top
// --------------------------------------------------------------------
// Operation
// - Two mode-select bits in serial control pick one of four modes.
// - Nine-bit modes with filter on: flag only for given or broadcast match.
// - Filter cleared: data frames with ninth bit zero are accepted and flagged.
// - Mode 1 with filter: stop bit replaces ninth bit; match needs valid stop.
// - Mode 0 ignores the filter enable bit entirely.
// - Mask zero bits are ignored; mask one bits compare against station address.
// - Broadcast is address OR mask; zero result bits are ignored.
// - Address and mask reset to zero, so every address matches.
module uaar_top
	import uaar_pkg::*;
(
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr_stb,
	input  wire logic       i_rd_stb,
	output logic      [7:0] o_rdata,
	input  wire logic       i_rx_valid,
	output logic            o_rx_ready,
	input  wire logic [7:0] i_rx_data,
	input  wire logic       i_rx_bit9,
	output logic      [1:0] o_serial_mode,
	output logic            o_receive_done_flag
);

	// --------------------------------------------------------------------
	// Match function
	// --------------------------------------------------------------------
	function automatic logic addr_match(
		input logic [7:0] rx,
		input logic [7:0] addr,
		input logic [7:0] mask
	);
		logic [7:0] bcast;
		logic       given_hit;
		logic       bcast_hit;
		bcast     = addr | mask;
		given_hit = (((rx ^ addr) & mask) == 8'h00);
		bcast_hit = (((rx ^ bcast) & bcast) == 8'h00);
		return given_hit || bcast_hit;
	endfunction

	// --------------------------------------------------------------------
	// Declarations
	// --------------------------------------------------------------------
	localparam int LW = $clog2(UAAR_FIFO_DEPTH) + 1;

	logic [1:0]                 mode_q;
	logic [1:0]                 mode_d;
	logic                       addr_filt_q;
	logic                       addr_filt_d;
	logic                       rx_done_q;
	logic                       rx_done_d;
	logic [7:0]                 station_addr_q;
	logic [7:0]                 station_addr_d;
	logic [7:0]                 station_mask_q;
	logic [7:0]                 station_mask_d;
	logic [7:0]                 rdata_q;
	logic [7:0]                 rdata_d;

	logic                       sel_ctrl;
	logic                       sel_data;
	logic                       sel_station_address;
	logic                       sel_smask;
	logic                       sel_stat;
	logic                       wr_ctrl;
	logic                       wr_station_address;
	logic                       wr_smask;
	logic                       rd_data;

	logic                       is_match;
	logic                       mode_shift;
	logic                       mode_8bit;
	logic                       mode_9bit;
	logic                       accept;
	logic                       push_valid;
	logic                       push_ready;
	logic                       push;

	logic                       head_valid;
	logic [UAAR_FIFO_WIDTH-1:0] head_data;
	logic [LW-1:0]              fifo_level;
	logic [7:0]                 ctrl_view;
	logic [7:0]                 stat_view;

	// --------------------------------------------------------------------
	// Register decode
	// --------------------------------------------------------------------
	assign sel_ctrl  = (i_addr == UAAR_OFS_SERIAL_CONTROL);
	assign sel_data  = (i_addr == UAAR_OFS_RX_DATA);
	assign sel_station_address = (i_addr == UAAR_OFS_STATION_ADDR);
	assign sel_smask = (i_addr == UAAR_OFS_STATION_MASK);
	assign sel_stat  = (i_addr == UAAR_OFS_RX_STATUS);

	// --------------------------------------------------------------------
	// Write and read strobes
	// --------------------------------------------------------------------
	assign wr_ctrl   = i_wr_stb && sel_ctrl;
	assign wr_station_address  = i_wr_stb && sel_station_address;
	assign wr_smask  = i_wr_stb && sel_smask;
	assign rd_data   = i_rd_stb && sel_data && head_valid;

	// --------------------------------------------------------------------
	// Mode decode
	// --------------------------------------------------------------------
	assign mode_shift = (mode_q == UAAR_MODE_SHIFT);
	assign mode_8bit  = (mode_q == UAAR_MODE_8BIT);
	assign mode_9bit  = (mode_q == UAAR_MODE_9BIT_F) ||
	                    (mode_q == UAAR_MODE_9BIT_V);

	// --------------------------------------------------------------------
	// Frame acceptance
	// --------------------------------------------------------------------
	assign is_match = addr_match(i_rx_data, station_addr_q, station_mask_q);

	// Filter off or mode 0: all frames pass; filter on: marked match only
	assign accept = mode_shift ? 1'b1 :
	                !addr_filt_q ? 1'b1 :
	                mode_8bit ? (i_rx_bit9 && is_match) :
	                mode_9bit ? (i_rx_bit9 && is_match) :
	                1'b0;

	assign push_valid = i_rx_valid && accept;
	assign push       = push_valid && push_ready;

	// Rejected frames are dropped at once; accepted ones wait for room
	assign o_rx_ready = accept ? push_ready : 1'b1;

	// --------------------------------------------------------------------
	// Receive buffer instance
	// --------------------------------------------------------------------
	uaar_fifo #(
		.WIDTH (UAAR_FIFO_WIDTH),
		.DEPTH (UAAR_FIFO_DEPTH)
	) u_fifo (
		.i_mclk      (i_mclk),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (push_valid),
		.o_in_ready  (push_ready),
		.i_in_data   ({i_rx_bit9, i_rx_data}),
		.o_out_valid (head_valid),
		.i_out_ready (rd_data),
		.o_out_data  (head_data),
		.o_level     (fifo_level)
	);

	// --------------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------------
	assign mode_d = wr_ctrl ? {i_wdata[UAAR_BIT_MODE_HI], i_wdata[UAAR_BIT_MODE_LO]}
	                        : mode_q;
	assign addr_filt_d    = wr_ctrl ? i_wdata[UAAR_BIT_ADDR_FILT] : addr_filt_q;
	assign station_addr_d = wr_station_address ? i_wdata : station_addr_q;
	assign station_mask_d = wr_smask ? i_wdata : station_mask_q;

	// Hardware set wins over a software clear in the same cycle
	assign rx_done_d = (wr_ctrl ? i_wdata[UAAR_BIT_RX_DONE] : rx_done_q) | push;

	// --------------------------------------------------------------------
	// Read views
	// --------------------------------------------------------------------
	always_comb begin
		ctrl_view                    = 8'h00;
		ctrl_view[UAAR_BIT_MODE_HI]  = mode_q[1];
		ctrl_view[UAAR_BIT_MODE_LO]  = mode_q[0];
		ctrl_view[UAAR_BIT_ADDR_FILT] = addr_filt_q;
		ctrl_view[UAAR_BIT_RX_BIT9]  = head_valid && head_data[8];
		ctrl_view[UAAR_BIT_RX_DONE]  = rx_done_q;
	end

	// --------------------------------------------------------------------
	// Status view
	// --------------------------------------------------------------------
	always_comb begin
		stat_view                                   = 8'h00;
		stat_view[UAAR_POS_FIFO_LEVEL +: LW]        = fifo_level;
		stat_view[UAAR_BIT_FIFO_FULL]               = !push_ready;
	end

	// --------------------------------------------------------------------
	// Read data select
	// --------------------------------------------------------------------
	// Unmapped offsets and an empty buffer read as zero
	assign rdata_d = !i_rd_stb ? rdata_q :
	                 sel_ctrl  ? ctrl_view :
	                 sel_data  ? (head_valid ? head_data[7:0] : 8'h00) :
	                 sel_station_address ? station_addr_q :
	                 sel_smask ? station_mask_q :
	                 sel_stat  ? stat_view :
	                 8'h00;

	// --------------------------------------------------------------------
	// Control register
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mode_q      <= UAAR_RST_MODE;
			addr_filt_q <= UAAR_RST_ADDR_FILT;
		end else begin
			mode_q      <= mode_d;
			addr_filt_q <= addr_filt_d;
		end
	end

	// --------------------------------------------------------------------
	// Receive done flag
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rx_done_q <= UAAR_RST_RX_DONE;
		end else begin
			rx_done_q <= rx_done_d;
		end
	end

	// --------------------------------------------------------------------
	// Station address and mask
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			station_addr_q <= UAAR_RST_STATION_ADDR;
			station_mask_q <= UAAR_RST_STATION_MASK;
		end else begin
			station_addr_q <= station_addr_d;
			station_mask_q <= station_mask_d;
		end
	end

	// --------------------------------------------------------------------
	// Read data register
	// --------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= UAAR_RST_RDATA;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	assign o_rdata             = rdata_q;
	assign o_serial_mode       = mode_q;
	assign o_receive_done_flag = rx_done_q;

endmodule

`default_nettype wire

// ===== design/uaar_pkg.sv
// Purpose: Constants for the receive address recognition block
// Assumes: Byte-wide register port, one system clock
// Notes:   Offsets are register indices on the local register port
`default_nettype none

package uaar_pkg;

	// --------------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------------
	localparam logic [2:0] UAAR_OFS_SERIAL_CONTROL = 3'h0;
	localparam logic [2:0] UAAR_OFS_RX_DATA        = 3'h1;
	localparam logic [2:0] UAAR_OFS_STATION_ADDR   = 3'h2;
	localparam logic [2:0] UAAR_OFS_STATION_MASK   = 3'h3;
	localparam logic [2:0] UAAR_OFS_RX_STATUS      = 3'h4;

	// --------------------------------------------------------------------
	// Serial control fields
	// --------------------------------------------------------------------
	localparam int UAAR_BIT_MODE_HI   = 7;
	localparam int UAAR_BIT_MODE_LO   = 6;
	localparam int UAAR_BIT_ADDR_FILT = 5;
	localparam int UAAR_BIT_RX_BIT9   = 2;
	localparam int UAAR_BIT_RX_DONE   = 0;

	// --------------------------------------------------------------------
	// Receive status fields
	// --------------------------------------------------------------------
	localparam int UAAR_BIT_FIFO_FULL  = 7;
	localparam int UAAR_POS_FIFO_LEVEL = 0;

	// --------------------------------------------------------------------
	// Serial modes
	// --------------------------------------------------------------------
	localparam logic [1:0] UAAR_MODE_SHIFT  = 2'h0;
	localparam logic [1:0] UAAR_MODE_8BIT   = 2'h1;
	localparam logic [1:0] UAAR_MODE_9BIT_F = 2'h2;
	localparam logic [1:0] UAAR_MODE_9BIT_V = 2'h3;

	// --------------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------------
	localparam logic [7:0] UAAR_RST_STATION_ADDR = 8'h00;
	localparam logic [7:0] UAAR_RST_STATION_MASK = 8'h00;
	localparam logic [1:0] UAAR_RST_MODE         = 2'h0;
	localparam logic       UAAR_RST_ADDR_FILT    = 1'b0;
	localparam logic       UAAR_RST_RX_DONE      = 1'b0;
	localparam logic [7:0] UAAR_RST_RDATA        = 8'h00;

	// --------------------------------------------------------------------
	// Receive buffer shape
	// --------------------------------------------------------------------
	localparam int UAAR_FIFO_WIDTH = 9;
	localparam int UAAR_FIFO_DEPTH = 16;

endpackage

`default_nettype wire

// ===== verification/uaar_top_asserts.sv
// Purpose: Port checker for the address recognition top
// Assumes: Register writes on the port mirror address, mask and filter bit
// Notes:   Bound to uaar_top after the module
`timescale 1ns/100ps
`default_nettype none
module uaar_top_chk
	import uaar_pkg::*;
(
	input wire logic       i_mclk,
	input wire logic       i_rst_b,
	input wire logic [2:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr_stb,
	input wire logic       i_rx_valid,
	input wire logic       o_rx_ready,
	input wire logic [7:0] i_rx_data,
	input wire logic       i_rx_bit9,
	input wire logic [1:0] o_serial_mode,
	input wire logic       o_receive_done_flag
);
	// ------------------------------------------------------------
	// Register mirror and acceptance
	// ------------------------------------------------------------
	logic [7:0] addr_q;
	logic [7:0] mask_q;
	logic       filt_q;
	wire  logic       ctl_wr = i_wr_stb && (i_addr == UAAR_OFS_SERIAL_CONTROL);
	wire  logic       take   = i_rx_valid && o_rx_ready;
	wire  logic [7:0] bc     = addr_q | mask_q;
	wire  logic       gm     = ((i_rx_data ^ addr_q) & mask_q) == 8'h00;
	wire  logic       bm     = ((i_rx_data ^ bc) & bc) == 8'h00;
	wire  logic       fon    = filt_q && (o_serial_mode != UAAR_MODE_SHIFT);
	wire  logic       acc    = !fon || (i_rx_bit9 && (gm || bm));
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_q <= 8'h00;
			mask_q <= 8'h00;
			filt_q <= 1'b0;
		end else if (i_wr_stb) begin
			if (i_addr == UAAR_OFS_STATION_ADDR)
				addr_q <= i_wdata;
			if (i_addr == UAAR_OFS_STATION_MASK)
				mask_q <= i_wdata;
			if (ctl_wr)
				filt_q <= i_wdata[UAAR_BIT_ADDR_FILT];
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);
	property p_mode; ctl_wr |=> o_serial_mode == $past(i_wdata[7:6]); endproperty
	a_mode: assert property (p_mode) else $error("mode select wrong");
	property p_given; take && fon && i_rx_bit9 && gm |=> o_receive_done_flag; endproperty
	a_given: assert property (p_given) else $error("given match not flagged");
	property p_bcast; take && fon && i_rx_bit9 && bm |=> o_receive_done_flag; endproperty
	a_bcast: assert property (p_bcast) else $error("broadcast not flagged");
	property p_nofilt; take && !filt_q && !i_rx_bit9 |=> o_receive_done_flag; endproperty
	a_nofilt: assert property (p_nofilt) else $error("data frame not flagged");
	property p_shift; take && o_serial_mode == UAAR_MODE_SHIFT |=> o_receive_done_flag; endproperty
	a_shift: assert property (p_shift) else $error("mode 0 frame not flagged");
	sequence s_badstop; take && fon && o_serial_mode == UAAR_MODE_8BIT && !i_rx_bit9; endsequence
	property p_stop; s_badstop ##0 !ctl_wr |=> $stable(o_receive_done_flag); endproperty
	a_stop: assert property (p_stop) else $error("bad stop bit flagged");
	property p_hold; take && !acc && !ctl_wr |=> $stable(o_receive_done_flag); endproperty
	a_hold: assert property (p_hold) else $error("rejected frame moved flag");
	property p_rstm; take && fon && i_rx_bit9 && addr_q == 8'h00 && mask_q == 8'h00 |=> o_receive_done_flag; endproperty
	a_rstm: assert property (p_rstm) else $error("zero address did not match");
	c_acc: cover property (take && fon && acc);
	c_rej: cover property (take && !acc);
	c_full: cover property ((i_rx_valid && !o_rx_ready) [*2]);
endmodule
bind uaar_top uaar_top_chk u_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr_stb(i_wr_stb), .i_rx_valid(i_rx_valid), .o_rx_ready(o_rx_ready),
	.i_rx_data(i_rx_data), .i_rx_bit9(i_rx_bit9), .o_serial_mode(o_serial_mode),
	.o_receive_done_flag(o_receive_done_flag));
`default_nettype wire

// ===== verification/uaar_master.sv
// Purpose: Master station on the shared line, offering whole frames
// Assumes: Frame offered on go, held until the receiver takes it
// Notes:   Released lines turn over so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module uaar_master (
	input  wire logic       i_mclk,
	input  wire logic       i_rst_b,
	input  wire logic       i_go,
	input  wire logic [7:0] i_data,
	input  wire logic       i_bit9,
	input  wire logic       i_rx_ready,
	output logic            o_rx_valid,
	output logic      [7:0] o_rx_data,
	output logic            o_rx_bit9
);
	// Ninth bit one marks address, zero marks data
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_rx_valid <= 1'b0;
			o_rx_data  <= 8'h00;
			o_rx_bit9  <= 1'b0;
		end else if (i_go && !o_rx_valid) begin
			o_rx_valid <= 1'b1;
			o_rx_data  <= i_data;
			o_rx_bit9  <= i_bit9;
		end else if (o_rx_valid && i_rx_ready) begin
			o_rx_valid <= 1'b0;
			o_rx_data  <= ~o_rx_data;
			o_rx_bit9  <= ~o_rx_bit9;
		end
	end
endmodule
`default_nettype wire

// ===== verification/uaar_top_test.sv
// Purpose: Self-checking bench for the address recognition top
// Assumes: Master model offers frames, bench runs the register port
// Notes:   Table of filter cases, then reset and buffer cases
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
	$display("Error t=%0t got %h exp %h", $time, g, e); end end
module uaar_top_test;
	import uaar_pkg::*;
	typedef struct packed {logic [1:0] m; logic f; logic [7:0] a; logic [7:0] k;
		logic [7:0] d; logic b; logic e;} uaar_row_t;
	logic       i_mclk = 1'b0, i_rst_b = 1'b0, i_wr_stb = 1'b0, i_rd_stb = 1'b0;
	logic       go = 1'b0, bit9 = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00, data = 8'h00, rdv;
	wire  logic [7:0] o_rdata, rx_data;
	wire  logic [1:0] o_serial_mode;
	wire  logic       o_rx_ready, rx_valid, rx_bit9, flag;
	int         fail_count = 0, checks = 0;
	// Mode, filter, address, mask, frame byte, ninth bit, flag expected
	uaar_row_t  rows [12] = '{{2'h3, 1'b1, 8'hF1, 8'hFA, 8'hF0, 1'b1, 1'b1},
		{2'h3, 1'b1, 8'hF1, 8'hFA, 8'hF4, 1'b1, 1'b1}, {2'h3, 1'b1, 8'hF3, 8'hF9, 8'hF0, 1'b1, 1'b0},
		{2'h3, 1'b1, 8'hF1, 8'hFA, 8'hFB, 1'b1, 1'b1}, {2'h2, 1'b1, 8'h0F, 8'hF0, 8'hFF, 1'b1, 1'b1},
		{2'h2, 1'b1, 8'hF1, 8'hFA, 8'hF0, 1'b0, 1'b0}, {2'h3, 1'b0, 8'hF1, 8'hFA, 8'h55, 1'b0, 1'b1},
		{2'h1, 1'b1, 8'hF1, 8'hFA, 8'hF0, 1'b1, 1'b1}, {2'h1, 1'b1, 8'hF1, 8'hFA, 8'hF0, 1'b0, 1'b0},
		{2'h0, 1'b1, 8'hF1, 8'hFA, 8'h55, 1'b0, 1'b1}, {2'h3, 1'b1, 8'hF9, 8'hF5, 8'hF1, 1'b1, 1'b1},
		{2'h3, 1'b1, 8'hF9, 8'hF5, 8'hF2, 1'b1, 1'b0}};
	uaar_top uut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata), .i_rx_valid(rx_valid),
		.o_rx_ready(o_rx_ready), .i_rx_data(rx_data), .i_rx_bit9(rx_bit9),
		.o_serial_mode(o_serial_mode), .o_receive_done_flag(flag));
	uaar_master u_master (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_go(go), .i_data(data),
		.i_bit9(bit9), .i_rx_ready(o_rx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
		.o_rx_bit9(rx_bit9));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr_stb <= 1'b1;
		@(posedge i_mclk);
		i_wr_stb <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [2:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_mclk);
		i_rd_stb <= 1'b0;
		#1 rdv = o_rdata;
	endtask
	task automatic send(input logic [7:0] d, input logic b, input int n);
		@(posedge i_mclk);
		data <= d;
		bit9 <= b;
		go <= 1'b1;
		@(posedge i_mclk);
		go <= 1'b0;
		#1;
		for (int i = 0; i < n && rx_valid === 1'b1; i++) begin
			@(posedge i_mclk);
			#1;
		end
	endtask
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	always #25 i_mclk = ~i_mclk;
	initial begin
		#300000;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (5) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		foreach (rows[i]) begin
			wr(UAAR_OFS_STATION_MASK, rows[i].k);
			wr(UAAR_OFS_STATION_ADDR, rows[i].a);
			wr(UAAR_OFS_SERIAL_CONTROL, {rows[i].m, rows[i].f, 5'h00});
			`CHK(o_serial_mode, rows[i].m)
			send(rows[i].d, rows[i].b, 20);
			`CHK(flag, rows[i].e)
			if (rows[i].e) begin
				rd(UAAR_OFS_RX_DATA);
				`CHK(rdv, rows[i].d)
			end
		end
		@(posedge i_mclk);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		rd(UAAR_OFS_STATION_ADDR);
		`CHK(rdv, UAAR_RST_STATION_ADDR)
		rd(UAAR_OFS_STATION_MASK);
		`CHK(rdv, UAAR_RST_STATION_MASK)
		wr(UAAR_OFS_SERIAL_CONTROL, 8'hE0);
		send(8'h37, 1'b1, 20);
		`CHK(flag, 1'b1)
		rd(UAAR_OFS_SERIAL_CONTROL);
		`CHK(rdv, 8'hE5)
		rd(UAAR_OFS_RX_DATA);
		`CHK(rdv, 8'h37)
		rd(3'h5);
		`CHK(rdv, 8'h00)
		wr(UAAR_OFS_SERIAL_CONTROL, 8'h00);
		`CHK(flag, 1'b0)
		for (int i = 0; i < 16; i++)
			send(8'(i), 1'b0, 20);
		rd(UAAR_OFS_RX_STATUS);
		`CHK(rdv, 8'h90)
		send(8'hA5, 1'b0, 0);
		repeat (3) @(posedge i_mclk);
		#1;
		`CHK({rx_valid, o_rx_ready}, 2'h2)
		for (int i = 0; i < 17; i++) begin
			rd(UAAR_OFS_RX_DATA);
			`CHK(rdv, (i < 16) ? 8'(i) : 8'hA5)
		end
		rd(UAAR_OFS_RX_STATUS);
		`CHK(rdv, 8'h00)
		end_of_test();
	end
endmodule
`default_nettype wire
